// ### rtl/pinlogic_pkg.sv
// Purpose: Shared constants and carrier types for the status LED, wake and strap pin block
// Assumes: 100 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: Byte addresses are word aligned; all offsets below are byte addresses
package pinlogic_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BLINK_MS = 80;
	localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned STRAP_SETTLE = 3;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GPIO_CFG = 8'h04;
	localparam logic [7:0] OFS_GPIO_IN = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	localparam logic [7:0] OFS_INT_STATUS = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;

	// Control fields
	localparam int unsigned CTRL_WAKE_EN = 0;
	localparam int unsigned CTRL_WAKE_POL = 1;
	localparam int unsigned CTRL_WAKE_OD = 2;
	localparam int unsigned CTRL_SLEEP = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Pin configuration fields, three bits each
	localparam int unsigned CFG_VAL_LSB = 0;
	localparam int unsigned CFG_DIR_LSB = 4;
	localparam int unsigned CFG_OD_LSB = 8;
	localparam int unsigned CFG_LED_LSB = 12;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// Interrupt status bits
	localparam int unsigned EV_WAKE = 0;
	localparam int unsigned EV_HOST_WAKE = 1;
	localparam int unsigned EV_LINK = 2;
	localparam int unsigned EV_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic link_up;
		logic speed_100;
		logic autoneg_busy;
		logic full_duplex;
		logic activity;
	} phy_status_type;

	typedef enum logic [2:0] {
		ACT_IDLE = 3'b001,
		ACT_OFF = 3'b010,
		ACT_HOLD = 3'b100
	} act_state_type;

endpackage : pinlogic_pkg

// ### rtl/status_led_wake_pins.sv
// Purpose: Wake indicator, sleep exit, straps and three GPIO pins shared with LED indicators
// Assumes: Pin inputs are asynchronous; PHY status and wake events come from core-clock logic
// Notes: Output enables are active low; open-drain pins release by raising their enable
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module status_led_wake_pins
	import pinlogic_pkg::*;
#(
	parameter int unsigned BLINK_COUNT = pinlogic_pkg::BLINK_CYCLES,
	parameter int unsigned CNT_W = 24
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Core-side status
	input wire pinlogic_pkg::phy_status_type phy_status_in,
	input wire logic wake_event_in,
	output logic power_save_out,
	output logic crossover_enable_out,
	output logic default_speed_strap_out,
	output logic irq_out,
	// Pins
	input wire logic chip_select_n_in,
	input wire logic write_strobe_n_in,
	input wire logic crossover_auto_enable_in,
	input wire logic speed_select_strap_in,
	output logic wake_indicator_out,
	output logic wake_indicator_oe_n_out,
	input wire logic [2:0] gpio_in,
	output logic [2:0] gpio_out,
	output logic [2:0] gpio_oe_n_out
);
	import pinlogic_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] pins_raw;
	assign pins_raw = {gpio_in, speed_select_strap_in, crossover_auto_enable_in,
		chip_select_n_in & write_strobe_n_in};

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			// Strobe pair idles high, so no false host write edge after reset
			sync1_q <= 6'h01;
			sync2_q <= 6'h01;
		end
		else
		begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [3:0] ctrl_q;
	logic [15:0] cfg_q;
	logic [EV_W-1:0] status_q;
	logic [EV_W-1:0] mask_q;
	logic sleep_q;
	logic wake_asserted_q;
	logic [2:0] led_n_q;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_pend_q;

	// Write path: address and data taken together, one write in flight
	assign s_axi_awready_out = s_axi_awvalid_in & s_axi_wvalid_in & !s_axi_bvalid_out & !wr_pend_q;
	assign s_axi_wready_out = s_axi_awready_out;
	assign wr_fire = s_axi_awready_out;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end
		else
		begin
			wr_pend_q <= wr_fire;
			if (wr_fire)
			begin
				waddr_q <= s_axi_awaddr_in;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			if (wr_pend_q)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (waddr_q == OFS_CTRL || waddr_q == OFS_GPIO_CFG ||
					waddr_q == OFS_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	logic wr_ctrl;
	logic wr_cfg;
	logic wr_mask;
	assign wr_ctrl = wr_pend_q && waddr_q == OFS_CTRL && wstrb_q[0];
	assign wr_cfg = wr_pend_q && waddr_q == OFS_GPIO_CFG;
	assign wr_mask = wr_pend_q && waddr_q == OFS_INT_MASK && wstrb_q[0];

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_q <= CTRL_RESET;
			cfg_q <= CFG_RESET;
			mask_q <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= wdata_q[3:0];
			if (wr_cfg && wstrb_q[0])
				cfg_q[7:0] <= wdata_q[7:0];
			if (wr_cfg && wstrb_q[1])
				cfg_q[15:8] <= wdata_q[15:8];
			if (wr_mask)
				mask_q <= wdata_q[EV_W-1:0];
		end
	end

	// ****************************************
	// Sleep and wake
	// ****************************************
	logic host_wr_q;
	logic host_wake;
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			host_wr_q <= 1'b0;
		else
			host_wr_q <= !sync2_q[0];
	end
	assign host_wake = !sync2_q[0] && !host_wr_q;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			sleep_q <= 1'b0;
		else if (sleep_q && host_wake)
			sleep_q <= 1'b0;
		else if (wr_ctrl && wdata_q[CTRL_SLEEP])
			sleep_q <= 1'b1;
	end
	assign power_save_out = sleep_q;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wake_asserted_q <= 1'b0;
		else if (wake_event_in && ctrl_q[CTRL_WAKE_EN])
			wake_asserted_q <= 1'b1;
		else if (!ctrl_q[CTRL_WAKE_EN] || (sleep_q && host_wake))
			wake_asserted_q <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wake_indicator_out <= 1'b0;
			wake_indicator_oe_n_out <= 1'b1;
		end
		else if (ctrl_q[CTRL_WAKE_OD])
		begin
			wake_indicator_out <= 1'b0;
			wake_indicator_oe_n_out <= wake_asserted_q == ctrl_q[CTRL_WAKE_POL];
		end
		else
		begin
			wake_indicator_out <= wake_asserted_q ~^ ctrl_q[CTRL_WAKE_POL];
			wake_indicator_oe_n_out <= 1'b0;
		end
	end

	// ****************************************
	// Straps
	// ****************************************
	logic [1:0] strap_cnt_q;
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			strap_cnt_q <= 2'h0;
			default_speed_strap_out <= 1'b0;
			crossover_enable_out <= 1'b0;
		end
		else
		begin
			if (strap_cnt_q != 2'(STRAP_SETTLE))
			begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
				if (strap_cnt_q == 2'(STRAP_SETTLE - 1))
					default_speed_strap_out <= sync2_q[2];
			end
			crossover_enable_out <= sync2_q[1];
		end
	end

	// ****************************************
	// LED indicators
	// ****************************************
	act_state_type act_q;
	logic [CNT_W-1:0] act_cnt_q;
	logic act_pend_q;
	logic act_done;
	assign act_done = act_cnt_q == CNT_W'(BLINK_COUNT - 1);

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			act_q <= ACT_IDLE;
			act_cnt_q <= '0;
			act_pend_q <= 1'b0;
		end
		else if (!phy_status_in.link_up)
		begin
			act_q <= ACT_IDLE;
			act_cnt_q <= '0;
			act_pend_q <= 1'b0;
		end
		else
		begin
			act_cnt_q <= (act_q == ACT_IDLE || act_done) ? '0 : act_cnt_q + CNT_W'(1);
			unique case (act_q)
				ACT_IDLE:
				begin
					if (phy_status_in.activity)
						act_q <= ACT_OFF;
				end
				ACT_OFF:
				begin
					if (phy_status_in.activity)
						act_pend_q <= 1'b1;
					if (act_done)
						act_q <= ACT_HOLD;
				end
				ACT_HOLD:
				begin
					if (phy_status_in.activity)
						act_pend_q <= 1'b1;
					if (act_done)
					begin
						act_q <= (act_pend_q || phy_status_in.activity) ? ACT_OFF : ACT_IDLE;
						act_pend_q <= 1'b0;
					end
				end
				default:
					act_q <= ACT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			led_n_q <= 3'h7;
		else
		begin
			led_n_q[0] <= phy_status_in.link_up && !phy_status_in.autoneg_busy &&
				!phy_status_in.speed_100;
			// low on link, high while in ACT_OFF during a blink
			led_n_q[1] <= !phy_status_in.link_up || act_q == ACT_OFF;
			led_n_q[2] <= !(phy_status_in.link_up && phy_status_in.full_duplex);
		end
	end

	// ****************************************
	// GPIO pins
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pin
			always_ff @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
				begin
					gpio_out[gi] <= 1'b0;
					gpio_oe_n_out[gi] <= 1'b1;
				end
				else if (cfg_q[CFG_LED_LSB + gi])
				begin
					gpio_out[gi] <= 1'b0;
					gpio_oe_n_out[gi] <= led_n_q[gi];
				end
				else if (!cfg_q[CFG_DIR_LSB + gi])
				begin
					gpio_out[gi] <= 1'b0;
					gpio_oe_n_out[gi] <= 1'b1;
				end
				else if (cfg_q[CFG_OD_LSB + gi])
				begin
					gpio_out[gi] <= 1'b0;
					gpio_oe_n_out[gi] <= cfg_q[CFG_VAL_LSB + gi];
				end
				else
				begin
					gpio_out[gi] <= cfg_q[CFG_VAL_LSB + gi];
					gpio_oe_n_out[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Interrupts and read path
	// ****************************************
	logic [EV_W-1:0] ev_set;
	logic link_q;
	logic rd_status;
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			link_q <= 1'b0;
		else
			link_q <= phy_status_in.link_up;
	end
	assign ev_set[EV_WAKE] = wake_event_in && ctrl_q[CTRL_WAKE_EN];
	assign ev_set[EV_HOST_WAKE] = sleep_q && host_wake;
	assign ev_set[EV_LINK] = phy_status_in.link_up != link_q;

	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
	assign rd_status = rd_fire && s_axi_araddr_in == OFS_INT_STATUS;

	// Set beats the read clear
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			status_q <= '0;
			irq_out <= 1'b0;
		end
		else
		begin
			status_q <= (rd_status ? '0 : status_q) | ev_set;
			irq_out <= |(status_q & mask_q);
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= RESP_OKAY;
			unique case (s_axi_araddr_in)
				OFS_CTRL: s_axi_rdata_out <= {28'h0000000, sleep_q, ctrl_q[2:0]};
				OFS_GPIO_CFG: s_axi_rdata_out <= {16'h0000, cfg_q};
				OFS_GPIO_IN: s_axi_rdata_out <= {29'h0000000, sync2_q[5:3]};
				OFS_STATE: s_axi_rdata_out <= {25'h0000000 == 25'h0 ? 25'h000000 : 25'h000000, led_n_q,
					default_speed_strap_out, crossover_enable_out, wake_asserted_q, sleep_q};
				OFS_INT_STATUS: s_axi_rdata_out <= {29'h0000000, status_q};
				OFS_INT_MASK: s_axi_rdata_out <= {29'h0000000, mask_q};
				default:
				begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready_in)
			s_axi_rvalid_out <= 1'b0;
	end

endmodule : status_led_wake_pins
`default_nettype wire

// ### tb/pin_rules_check_asserts.sv
// Purpose: Port checks for the pin block
// Assumes: GPIO_CFG written with all strobes on
// Notes: LED select tracked from bus writes
`timescale 1ns/1ns
`default_nettype none
module pin_rules_check
	import pinlogic_pkg::*;
#(
	parameter int unsigned BLINK_COUNT = 20
)
(
	// Clock, reset and bus
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	// Status and pins
	input wire pinlogic_pkg::phy_status_type phy_status_in,
	input wire logic power_save_out,
	input wire logic crossover_enable_out,
	input wire logic default_speed_strap_out,
	input wire logic chip_select_n_in,
	input wire logic write_strobe_n_in,
	input wire logic crossover_auto_enable_in,
	input wire logic wake_indicator_out,
	input wire logic wake_indicator_oe_n_out,
	input wire logic [2:0] gpio_out,
	input wire logic [2:0] gpio_oe_n_out
);
	logic [2:0] up_q;
	logic [2:0] led_q;
	logic [23:0] hi_q;
	logic spd_n;
	logic host_wr;
	assign spd_n = phy_status_in.link_up & ~phy_status_in.autoneg_busy & ~phy_status_in.speed_100;
	assign host_wr = ~chip_select_n_in & ~write_strobe_n_in;
	always_ff @(posedge clk_in or negedge nrst_in)
		if (!nrst_in)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	always_ff @(posedge clk_in or negedge nrst_in)
		if (!nrst_in)
			led_q <= 3'h0;
		else if (s_axi_awready_out && s_axi_wready_out && s_axi_awaddr_in == OFS_GPIO_CFG)
			led_q <= s_axi_wdata_in[14:12];
	// Length of the current high run of the link indicator
	always_ff @(posedge clk_in or negedge nrst_in)
		if (!nrst_in)
			hi_q <= 24'h0;
		else if (led_q[1] && gpio_oe_n_out[1] && phy_status_in.link_up)
			hi_q <= hi_q + 24'h1;
		else
			hi_q <= 24'h0;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	a_crossover_lag: assert property (up_q > 3'h3 |-> crossover_enable_out == $past(crossover_auto_enable_in, 3))
		else $error("crossover lag");
	a_strap_steady: assert property (up_q > 3'h4 |-> $stable(default_speed_strap_out))
		else $error("strap moved");
	a_sleep_cause: assert property ($fell(power_save_out) |-> $past(host_wr, 2))
		else $error("woke without host write");
	a_host_wake: assert property (power_save_out && $rose(host_wr) |-> ##[1:4] !power_save_out)
		else $error("host write ignored");
	a_wake_od_low: assert property (wake_indicator_oe_n_out |-> !wake_indicator_out)
		else $error("released wake pin data");
	a_speed_led: assert property (led_q[0] && $past(led_q[0], 3) |->
		!gpio_out[0] && gpio_oe_n_out[0] == $past(spd_n, 2))
		else $error("speed indicator");
	a_blink_len: assert property (hi_q <= BLINK_COUNT)
		else $error("blink too long");
	a_write_answer: assert property (s_axi_awready_out && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
		else $error("write answer late");
	c_host_wake: cover property ($fell(power_save_out));
	c_blink: cover property (hi_q == BLINK_COUNT);
	c_led_mode: cover property (led_q == 3'h7);
endmodule : pin_rules_check
bind status_led_wake_pins pin_rules_check #(.BLINK_COUNT(BLINK_COUNT)) rules_i (.clk_in, .nrst_in,
	.s_axi_awaddr_in, .s_axi_wdata_in, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bvalid_out,
	.phy_status_in, .power_save_out, .crossover_enable_out, .default_speed_strap_out, .chip_select_n_in,
	.write_strobe_n_in, .crossover_auto_enable_in, .wake_indicator_out, .wake_indicator_oe_n_out,
	.gpio_out, .gpio_oe_n_out);
`default_nettype wire

// ### tb/host_pins_model.sv
// Purpose: Host strobes, pull-ups and external pin drivers
// Assumes: LED and wake lines have pull-ups
// Notes: Released lines show the pull-up, or ext_val_in on a GPIO line whose ext_en_in is set, never the last value
`timescale 1ns/1ns
`default_nettype none
module host_pins_model
(
	// Clock and commands
	input wire logic clk_in,
	input wire logic write_req_in,
	input wire logic [2:0] ext_en_in,
	input wire logic [2:0] ext_val_in,
	// Device pins
	input wire logic [2:0] gpio_in,
	input wire logic [2:0] gpio_oe_n_in,
	input wire logic wake_in,
	input wire logic wake_oe_n_in,
	output logic [2:0] gpio_level_out,
	output logic wake_level_out,
	output logic chip_select_n_out,
	output logic write_strobe_n_out
);
	logic [2:0] hold_q = 3'h0;
	always @(posedge clk_in)
		if (write_req_in)
			hold_q <= 3'h4;
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
	assign chip_select_n_out = (hold_q == 3'h0);
	assign write_strobe_n_out = (hold_q == 3'h0);
	assign gpio_level_out = (~gpio_oe_n_in & gpio_in) | (gpio_oe_n_in & ((ext_en_in & ext_val_in) | ~ext_en_in));
	assign wake_level_out = wake_oe_n_in | wake_in;
endmodule : host_pins_model
`default_nettype wire

// ### tb/tb_status_led_wake_pins.sv
// Purpose: Self-checking bench for the pin block
// Assumes: Blink shortened to BC cycles
// Notes: Fixed-seed xorshift stimulus
`timescale 1ns/1ns
`default_nettype none
module tb_status_led_wake_pins;
	import pinlogic_pkg::*;
	localparam int unsigned BC = 20;
	logic clk_in = 1'b0, nrst_in = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic wev = 1'b0, xo = 1'b1, sp = 1'b1, hreq = 1'b0;
	logic [7:0] aa = 8'h00, ra = 8'h00;
	logic [31:0] wd = 32'h0, seed = 32'h00013F96, rd;
	logic [2:0] xen = 3'h0, xv = 3'h0, go, goe, gl;
	phy_status_type phy = '0;
	logic awr, wrr, bv, arr, rv, ps, xo_o, sp_o, irq, wo, woe, csn, wrn, wl;
	logic [1:0] bresp, rresp;
	int errors = 0, total_checks = 0;
	always #5 clk_in = ~clk_in;
	status_led_wake_pins #(.BLINK_COUNT(BC)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .s_axi_awaddr_in(aa),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(br), .s_axi_araddr_in(ra), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
		.phy_status_in(phy), .wake_event_in(wev), .power_save_out(ps), .crossover_enable_out(xo_o),
		.default_speed_strap_out(sp_o), .irq_out(irq), .chip_select_n_in(csn), .write_strobe_n_in(wrn),
		.crossover_auto_enable_in(xo), .speed_select_strap_in(sp), .wake_indicator_out(wo),
		.wake_indicator_oe_n_out(woe), .gpio_in(gl), .gpio_out(go), .gpio_oe_n_out(goe));
	host_pins_model far (.clk_in(clk_in), .write_req_in(hreq), .ext_en_in(xen), .ext_val_in(xv), .gpio_in(go),
		.gpio_oe_n_in(goe), .wake_in(wo), .wake_oe_n_in(woe), .gpio_level_out(gl), .wake_level_out(wl),
		.chip_select_n_out(csn), .write_strobe_n_out(wrn));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [2:0] led_exp(input phy_status_type p);
		return {~(p.link_up & p.full_duplex), ~p.link_up, p.link_up & ~p.autoneg_busy & ~p.speed_100};
	endfunction : led_exp
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_in);
		aa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge clk_in); while (!(awr === 1'b1 && wrr === 1'b1));
		awv <= 1'b0;
		wv <= 1'b0;
		br <= 1'b1;
		do @(posedge clk_in); while (bv !== 1'b1);
		chk(bresp, r);
		br <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
		@(posedge clk_in);
		ra <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk_in); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk_in); while (rv !== 1'b1);
		d = rd;
		chk(rresp, r);
		rr <= 1'b0;
	endtask : axr
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (5000) @(posedge clk_in);
		errors++;
		print_verdict();
	end
	initial
	begin
		logic [31:0] v, d;
		int hi;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		axr(OFS_GPIO_CFG, d, RESP_OKAY);
		chk(d, {16'h0, CFG_RESET});
		sp <= 1'b0;
		xo <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk({sp_o, xo_o}, 2'h2);
		$display("strap test done");
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			xen <= ~v[6:4];
			xv <= v[18:16];
			axw(OFS_GPIO_CFG, v & 32'h00000777, RESP_OKAY);
			repeat (4) @(posedge clk_in);
			chk({goe, go & v[6:4]}, {~v[6:4] | (v[10:8] & v[2:0]), v[6:4] & ~v[10:8] & v[2:0]});
			axr(OFS_GPIO_IN, d, RESP_OKAY);
			chk(d[2:0], (v[6:4] & v[2:0]) | (~v[6:4] & v[18:16]));
		end
		xen <= 3'h0;
		axw(OFS_GPIO_CFG, rnd() & 32'h00000777 | 32'h00007000, RESP_OKAY);
		for (int i = 0; i < 16; i++)
		begin
			v = rnd();
			phy <= v[4:0] & 5'h1E;
			repeat (4) @(posedge clk_in);
			chk({go, goe}, {3'h0, led_exp(phy)});
		end
		phy <= 5'h10;
		repeat (5) @(posedge clk_in);
		for (int n = 1; n <= 2; n++)
		begin
			hi = 0;
			for (int c = 0; c < 4 * BC; c++)
			begin
				phy.activity <= (c == 0) || (n == 2 && c == 10);
				@(posedge clk_in);
				hi += goe[1];
			end
			chk(hi, n * BC);
		end
		$display("gpio and led tests done");
		axw(OFS_INT_MASK, 32'h2, RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			axw(OFS_CTRL, {28'h0, 1'b1, k[1], k[0], 1'b1}, RESP_OKAY);
			axr(OFS_INT_STATUS, d, RESP_OKAY);
			wev <= 1'b1;
			@(posedge clk_in);
			wev <= 1'b0;
			repeat (4) @(posedge clk_in);
			chk({wl, woe, ps, irq}, {k[0], k[1] & k[0], 2'h2});
			axw(OFS_GPIO_IN, 32'h0, RESP_SLVERR);
			chk(ps, 1'b1);
			hreq <= 1'b1;
			@(posedge clk_in);
			hreq <= 1'b0;
			repeat (10) @(posedge clk_in);
			chk({wl, ps, irq}, {~k[0], 2'h1});
			axr(OFS_INT_STATUS, d, RESP_OKAY);
			chk(d[1:0], 2'h3);
			repeat (3) @(posedge clk_in);
			chk(irq, 1'b0);
		end
		axw(OFS_CTRL, 32'h2, RESP_OKAY);
		wev <= 1'b1;
		@(posedge clk_in);
		wev <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk({wl, woe}, 2'h0);
		axr(OFS_CTRL, d, RESP_OKAY);
		chk(d[3:0], 4'h2);
		axw(8'h40, 32'h0, RESP_SLVERR);
		axr(8'h40, d, RESP_SLVERR);
		chk(d, 32'h0);
		phy <= 5'h00;
		repeat (2) @(posedge clk_in);
		axr(OFS_INT_STATUS, d, RESP_OKAY);
		chk(d[2:0], 3'h4);
		$display("wake test done");
		print_verdict();
	end
endmodule : tb_status_led_wake_pins
`default_nettype wire
